// *** src/pif_pkg.sv ***
// Package: register map, field layout and carrier types of the peripheral flag register two
// Overview of operation
// - Bits 7 and 3 to 1 read as zero and ignore writes.
// - Bit 6 is set when the second comparator raises its request or when software writes a one to it.
// - Bit 5 is set when the first comparator raises its request or when software writes a one to it.
// - Bit 4 is set when the memory controller finishes a programming task or when software writes a one to it.
// - Bit 0 is set when the oscillator accumulator rolls over or when software writes a one to it.
// - Flags are set by hardware regardless of any individual or global enable state.
package pif_pkg;
   localparam logic [3:0] PIF_FLAGS_OFFSET = 4'h0;
   localparam logic [3:0] PIF_SOURCES_OFFSET = 4'h4;
   localparam int PIF_BIT_COMP_B = 6;
   localparam int PIF_BIT_COMP_A = 5;
   localparam int PIF_BIT_MEM_DONE = 4;
   localparam int PIF_BIT_OSC_ROLL = 0;
   localparam logic [7:0] PIF_IMPL_MASK = 8'h71;
   localparam logic [7:0] PIF_FLAGS_RESET = 8'h00;
   localparam logic [31:0] PIF_UNMAPPED_DATA = 32'h0000_0000;

   // One request line per flag source
   typedef struct packed {
      logic comparator_b;
      logic comparator_a;
      logic memory_done;
      logic oscillator_rollover;
   } pif_sources_t;

   // Wishbone request bundle from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pif_wb_req_t;
endpackage : pif_pkg

// *** src/pif_flag_bit.sv ***
// One sticky request flag with software load and hardware set
`timescale 1ns/100ps
module pif_flag_bit
   import pif_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic hw_set,
   input wire logic sw_write,
   input wire logic sw_value,
   output logic flag
);
   // Hardware set wins so an event in the clearing cycle is kept
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag <= PIF_FLAGS_RESET[0];
      end else if (hw_set) begin
         flag <= 1'b1;
      end else if (sw_write) begin
         flag <= sw_value;
      end
   end
endmodule : pif_flag_bit

// *** src/pif_flag_reg_two.sv ***
// Peripheral interrupt flag register two with a classic Wishbone slave
`timescale 1ns/100ps
module pif_flag_reg_two
   import pif_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire pif_wb_req_t wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pif_sources_t src,
   output logic [7:0] peripheral_irq_flags_two
);
   // Bus-side decode of the current cycle
   logic access;
   logic read_req;
   logic write_req;
   logic hit_flags;
   logic hit_sources;
   logic lane0_on;
   logic flag_write;
   logic next_ack;

   // Read path
   logic [31:0] next_rd_data;

   // Flag storage and its placement in the register
   logic [7:0] flags;
   logic [3:0] flag_q;

   // Hardware request path
   logic [3:0] src_vec;
   logic [3:0] src_prev;
   logic [3:0] hw_set;

   // Software write path
   logic [3:0] wr_vec;

   // A request counts once; the ack flop masks the second cycle of the same strobe
   assign access = wb_req.cyc && wb_req.stb && !wb_ack_o;

   // Direction split of a taken request
   assign read_req = access && !wb_req.we;
   assign write_req = access && wb_req.we;

   // Address match; the low nibble is the whole map
   assign hit_flags = (wb_req.adr == PIF_FLAGS_OFFSET);
   assign hit_sources = (wb_req.adr == PIF_SOURCES_OFFSET);

   // Only byte lane 0 carries register bits; other lanes are ignored
   assign lane0_on = wb_req.sel[0];

   // Flag write strobe; the source view is read-only, so writes there are dropped
   assign flag_write = write_req && hit_flags && lane0_on;

   // Every taken access is answered, mapped or not, so a master never hangs
   assign next_ack = access;

   // Single-cycle answer; ack drops the cycle after it was given
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= next_ack;
      end
   end

   // Request lines gathered high to low in flag order
   assign src_vec = {src.comparator_b, src.comparator_a, src.memory_done, src.oscillator_rollover};

   // Previous levels; reset value equals the idle level so no false edge follows reset
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         src_prev <= 4'h0;
      end else begin
         src_prev <= src_vec;
      end
   end

   // A held level sets its flag once, so software can clear it while the level stays up
   assign hw_set = src_vec & ~src_prev;

   // Written value for the four implemented bits, high to low
   assign wr_vec = {wb_req.dat[PIF_BIT_COMP_B], wb_req.dat[PIF_BIT_COMP_A],
                    wb_req.dat[PIF_BIT_MEM_DONE], wb_req.dat[PIF_BIT_OSC_ROLL]};

   // Second comparator flag; absent source on small parts simply never rises
   pif_flag_bit u_flag_comp_b (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hw_set(hw_set[3]),
      .sw_write(flag_write),
      .sw_value(wr_vec[3]),
      .flag(flag_q[3])
   );

   // First comparator flag
   pif_flag_bit u_flag_comp_a (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hw_set(hw_set[2]),
      .sw_write(flag_write),
      .sw_value(wr_vec[2]),
      .flag(flag_q[2])
   );

   // Memory programming done flag
   pif_flag_bit u_flag_mem_done (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hw_set(hw_set[1]),
      .sw_write(flag_write),
      .sw_value(wr_vec[1]),
      .flag(flag_q[1])
   );

   // Oscillator rollover flag
   pif_flag_bit u_flag_osc_roll (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .hw_set(hw_set[0]),
      .sw_write(flag_write),
      .sw_value(wr_vec[0]),
      .flag(flag_q[0])
   );

   // Place flags; unused positions tie to zero
   always_comb begin
      flags = 8'h00;
      flags[PIF_BIT_COMP_B] = flag_q[3];
      flags[PIF_BIT_COMP_A] = flag_q[2];
      flags[PIF_BIT_MEM_DONE] = flag_q[1];
      flags[PIF_BIT_OSC_ROLL] = flag_q[0];
      flags = flags & PIF_IMPL_MASK;
   end

   // Flag vector straight from the flops, no extra latency
   assign peripheral_irq_flags_two = flags;

   // Read selection; unmapped offsets return zero so no stale data leaks out
   always_comb begin
      next_rd_data = PIF_UNMAPPED_DATA;
      if (hit_flags) begin
         next_rd_data = {24'h00_0000, flags};
      end else if (hit_sources) begin
         next_rd_data = {28'h000_0000, src_vec};
      end
   end

   // Read data registered alongside ack and held until the next read
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (read_req) begin
         wb_dat_o <= next_rd_data;
      end
   end
endmodule : pif_flag_reg_two

// *** sim/pif_flag_reg_two_properties.sv ***
// Checker for flag register two
`timescale 1ns/100ps
module pif_chk import pif_pkg::*;(input wire logic sys_clk,rst_b,input wire pif_wb_req_t wb_req,
input wire logic [31:0] wb_dat_o,input wire logic wb_ack_o,input wire pif_sources_t src,
input wire logic [7:0] peripheral_irq_flags_two);
wire logic [7:0] f=peripheral_irq_flags_two;
default clocking @(posedge sys_clk);endclocking
default disable iff(!rst_b);
sequence s_tk;wb_req.cyc&&wb_req.stb&&!wb_ack_o&&wb_req.adr==0;endsequence
property p_un;(f&~PIF_IMPL_MASK)==0;endproperty
a_un:assert property(p_un)else $error("spare");
property p_cb;$rose(src.comparator_b)|=>f[6];endproperty
a_cb:assert property(p_cb)else $error("b6");
property p_ca;$rose(src.comparator_a)|=>f[5];endproperty
a_ca:assert property(p_ca)else $error("b5");
property p_md;$rose(src.memory_done)|=>f[4];endproperty
a_md:assert property(p_md)else $error("b4");
property p_os;$rose(src.oscillator_rollover)|=>f[0];endproperty
a_os:assert property(p_os)else $error("b0");
property p_wr;s_tk##0(wb_req.we&&wb_req.sel[0]&&$stable(src))|=>f==($past(wb_req.dat[7:0])&PIF_IMPL_MASK);endproperty
a_wr:assert property(p_wr)else $error("wr");
property p_rd;s_tk##0!wb_req.we|=>wb_dat_o=={24'h0,$past(f)};endproperty
a_rd:assert property(p_rd)else $error("rd");
property p_ak;s_tk|=>wb_ack_o##1!wb_ack_o;endproperty
a_ak:assert property(p_ak)else $error("ack");
endmodule:pif_chk
bind pif_flag_reg_two pif_chk u_chk(.sys_clk(sys_clk),.rst_b(rst_b),.wb_req(wb_req),.wb_dat_o(wb_dat_o),
.wb_ack_o(wb_ack_o),.src(src),.peripheral_irq_flags_two(peripheral_irq_flags_two));

// *** sim/tb_top.sv ***
// Bench for flag register two
`timescale 1ns/100ps
module tb_top;
import pif_pkg::*;
logic sys_clk=0,rst_b=0,ack;logic [31:0] d;int err_count=0,compares=0,i;pif_wb_req_t rq='0;pif_sources_t src='0;
logic [11:0] rows[5]='{12'h840,12'h420,12'h210,12'h101,12'hf71};logic [7:0] fl;
pif_flag_reg_two dut(.sys_clk,.rst_b,.wb_req(rq),.wb_dat_o(d),.wb_ack_o(ack),.src,.peripheral_irq_flags_two(fl));
initial forever #2 sys_clk=~sys_clk;
task wrap_up;$display("errors %0d of %0d",err_count,compares);
if(err_count==0&&compares>0)$display("TB: PASS");else $display("TB: FAIL");$finish;endtask:wrap_up
task c(input logic [31:0] s,input logic [7:0] e,input string n="read");
compares++;if(s!=={24'h0,e})begin err_count++;$display("ERROR %s expected %h seen %h",n,e,s);end endtask:c
// Sources change with the request, so a rise can meet a write
task b(input logic w,input logic [3:0] a,input logic [7:0] v,input logic [3:0] l=1,input pif_sources_t s=0);
@(posedge sys_clk);rq<='{1,1,w,a,l,{24'h0,v}};src<=s;
for(i=0;i<9&&ack!==1;i++)@(posedge sys_clk);
rq<='0;if(ack!==1)begin err_count++;wrap_up;end endtask:b
initial begin repeat(20)@(posedge sys_clk);rst_b<=1;
foreach(rows[k])begin b(1,0,0,1,rows[k][11:8]);b(0,0,0);c(d,rows[k][7:0]);
c({24'h0,fl},rows[k][7:0],"flags");
b(1,0,0);b(0,0,0);c(d,0);c({24'h0,fl},0,"flags");end
b(1,0,8'hff);b(0,0,0);c(d,8'h71);b(1,0,0,0);b(0,0,0);c(d,8'h71);b(0,8,0);c(d,0);
b(0,4,0,1,4'hf);c(d,8'h0f,"sources");c({24'h0,fl},8'h71,"flags");
src<='0;rst_b<=0;repeat(2)@(posedge sys_clk);c(d,0,"dat");c({24'h0,fl},0,"flags");c({31'h0,ack},0,"ack");
rst_b<=1;b(0,0,0);c(d,0);c({24'h0,fl},0,"flags");
wrap_up;end
endmodule:tb_top
